// File: rtl/ulm_line_modes.v
// serial line modes: infrared filter, rs485, modem lines, channel routing
`timescale 1ns/1ps
`include "ulm_defs.vh"

// Summary of operation
// - infrared filter holds an 8-bit down counter loaded from filter value
// - falling edge on receive pin starts counter, one step per clock
// - rising edge stops the counter and reloads the filter value
// - counter at zero before rising edge drives receiver low one bit
// - mode code 0x1 selects rs485, other settings unchanged
// - in rs485 rts is the inverse of transmitter empty
// - in rs485 rts stays high through a programmed timeguard
// - mode code 0x3 selects modem mode, driving dtr and rts
// - disable command drives pin high, enable command drives pin low
// - modem mode flags each ri, dsr, dcd, cts level change
// - reading channel status clears the four change flags
// - cts high disables transmitter after the current character
// - normal routing: rxd to receiver, transmitter to txd
// - echo routing: rxd copied to txd, receiver still active
// - local loopback: transmitter to receiver, txd held high
// - remote loopback: rxd straight to txd, tx and rx disabled
// - channel mode 00 normal, 01 echo, 10 local, 11 remote
// - mode code 0x8 selects infrared demodulation, transmit path not modulated
module ulm_line_modes (
   input  wire        clk_sys,
   input  wire        nrst,
   input  wire [7:0]  avs_address,
   input  wire        avs_read,
   input  wire        avs_write,
   input  wire [31:0] avs_writedata,
   output wire [31:0] avs_readdata,
   output wire        avs_waitrequest,
   input  wire        rxd_pin,
   output wire        txd_pin,
   output wire        rts_pin,
   output wire        dtr_pin,
   input  wire        cts_pin,
   input  wire        dsr_pin,
   input  wire        dcd_pin,
   input  wire        ri_pin,
   input  wire        tx_bit,
   input  wire        tx_empty,
   input  wire        tx_shifting,
   input  wire        tg_active,
   input  wire [8:0]  rx_hold_data,
   input  wire [7:0]  err_count,
   output wire        rx_in,
   output wire        tx_allow,
   output wire        txrx_off,
   output wire [15:0] cmd_pulse,
   output wire        thr_wr,
   output wire [8:0]  thr_data,
   output wire [31:0] mode_cfg,
   output wire [31:0] baud_cfg,
   output wire [31:0] rto_cfg,
   output wire [31:0] tg_cfg,
   output wire [31:0] fidi_cfg,
   output wire [31:0] man_cfg,
   output wire        irq
);

   // ************************************************************
   // bus slave
   // ************************************************************
   reg         ack_ff;
   reg  [31:0] rdata_ff;
   reg  [31:0] nxt_rdata;
   wire        req;
   wire        wr_go;
   wire        rd_go;

   assign req             = avs_read | avs_write;
   assign avs_waitrequest = req & ~ack_ff;
   assign avs_readdata    = rdata_ff;
   assign wr_go           = avs_write & ack_ff;
   assign rd_go           = avs_read & ack_ff;

   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         ack_ff   <= 1'b0;
         rdata_ff <= `ULM_RST_ZERO;
      end else begin
         ack_ff   <= req & ~ack_ff;
         rdata_ff <= nxt_rdata;
      end
   end

   // ************************************************************
   // configuration registers
   // ************************************************************
   reg  [31:0] mr_ff;
   reg  [31:0] brgr_ff;
   reg  [31:0] rtor_ff;
   reg  [31:0] ttgr_ff;
   reg  [31:0] fidi_ff;
   reg  [31:0] man_ff;
   reg  [7:0]  if_ff;
   reg  [3:0]  imr_ff;
   reg  [15:0] cmd_ff;
   reg         thr_wr_ff;
   reg  [8:0]  thr_ff;
   wire        wr_cr;
   wire [3:0]  mode;
   wire [1:0]  chm;
   wire        is_rs485;
   wire        is_modem;
   wire        is_irda;

   assign wr_cr = wr_go & (avs_address == `ULM_OFS_CR);
   assign mode  = mr_ff[`ULM_MR_MODE_LO +: 4];
   assign chm   = mr_ff[`ULM_MR_CHM_LO +: 2];

   assign is_rs485 = (mode == `ULM_MODE_RS485);
   assign is_modem = (mode == `ULM_MODE_MODEM);
   assign is_irda  = (mode == `ULM_MODE_IRDA);

   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         mr_ff     <= `ULM_RST_ZERO;
         brgr_ff   <= `ULM_RST_ZERO;
         rtor_ff   <= `ULM_RST_ZERO;
         ttgr_ff   <= `ULM_RST_ZERO;
         fidi_ff   <= `ULM_RST_FIDI;
         man_ff    <= `ULM_RST_ZERO;
         if_ff     <= `ULM_RST_IF;
         imr_ff    <= 4'h0;
         cmd_ff    <= 16'h0000;
         thr_wr_ff <= 1'b0;
         thr_ff    <= 9'h000;
      end else begin
         cmd_ff    <= wr_cr ? avs_writedata[15:0] : 16'h0000;
         thr_wr_ff <= wr_go & (avs_address == `ULM_OFS_THR);
         if (wr_go) begin
            case (avs_address)
               `ULM_OFS_MR:   mr_ff   <= avs_writedata;
               `ULM_OFS_BRGR: brgr_ff <= avs_writedata;
               `ULM_OFS_RTOR: rtor_ff <= avs_writedata;
               `ULM_OFS_TTGR: ttgr_ff <= avs_writedata;
               `ULM_OFS_FIDI: fidi_ff <= avs_writedata;
               `ULM_OFS_MAN:  man_ff  <= avs_writedata;
               `ULM_OFS_IF:   if_ff   <= avs_writedata[7:0];
               `ULM_OFS_THR:  thr_ff  <= avs_writedata[8:0];
               `ULM_OFS_IER: begin
                  imr_ff <= imr_ff | avs_writedata[19:16];
               end
               `ULM_OFS_IDR: begin
                  imr_ff <= imr_ff & ~avs_writedata[19:16];
               end
               default: begin
                  imr_ff <= imr_ff;
               end
            endcase
         end
      end
   end

   assign cmd_pulse = cmd_ff;
   assign thr_wr    = thr_wr_ff;
   assign thr_data  = thr_ff;
   assign mode_cfg  = mr_ff;
   assign baud_cfg  = brgr_ff;
   assign rto_cfg   = rtor_ff;
   assign tg_cfg    = ttgr_ff;
   assign fidi_cfg  = fidi_ff;
   assign man_cfg   = man_ff;

   // ************************************************************
   // modem outputs
   // ************************************************************
   reg  rts_ctl_ff;
   reg  dtr_ff;
   reg  rts_out_ff;
   reg  nxt_rts_ctl;
   reg  nxt_dtr;

   always @* begin
      nxt_rts_ctl = rts_ctl_ff;
      nxt_dtr     = dtr_ff;
      if (wr_cr) begin
         if (avs_writedata[`ULM_CR_RTS_ON])
            nxt_rts_ctl = 1'b0;
         if (avs_writedata[`ULM_CR_DTR_ON])
            nxt_dtr = 1'b0;
         if (avs_writedata[`ULM_CR_RTS_OFF])
            nxt_rts_ctl = 1'b1;
         if (avs_writedata[`ULM_CR_DTR_OFF])
            nxt_dtr = 1'b1;
      end
   end

   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         rts_ctl_ff <= 1'b1;
         dtr_ff     <= 1'b1;
         rts_out_ff <= 1'b1;
      end else begin
         rts_ctl_ff <= nxt_rts_ctl;
         dtr_ff     <= nxt_dtr;
         if (is_rs485)
            rts_out_ff <= ~tx_empty | tg_active;
         else
            rts_out_ff <= nxt_rts_ctl;
      end
   end

   assign rts_pin = rts_out_ff;
   assign dtr_pin = dtr_ff;

   // ************************************************************
   // input change detection and status
   // ************************************************************
   reg  [3:0] lvl_ff;
   reg  [3:0] chg_ff;
   reg  [3:0] nxt_chg;
   wire [3:0] lvl_now;
   wire [3:0] chg_evt;
   wire       rd_csr;

   assign lvl_now = {cts_pin, dcd_pin, dsr_pin, ri_pin};
   assign rd_csr  = rd_go & (avs_address == `ULM_OFS_CSR);
   assign chg_evt = is_modem ? (lvl_now ^ lvl_ff) : 4'h0;

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_chg
         always @* begin
            nxt_chg[gi] = rd_csr ? 1'b0 : chg_ff[gi];
            if (chg_evt[gi])
               nxt_chg[gi] = 1'b1;
         end
      end
   endgenerate

   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         lvl_ff <= 4'hF;
         chg_ff <= 4'h0;
      end else begin
         lvl_ff <= lvl_now;
         chg_ff <= nxt_chg;
      end
   end

   assign irq = |(chg_ff & imr_ff);

   // ************************************************************
   // clear-to-send transmit gate
   // ************************************************************
   reg tx_allow_ff;

   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         tx_allow_ff <= 1'b1;
      end else begin
         if (!is_modem || !cts_pin)
            tx_allow_ff <= 1'b1;
         else if (!tx_shifting)
            tx_allow_ff <= 1'b0;
      end
   end

   assign tx_allow = tx_allow_ff & (chm != `ULM_CHM_REMOTE);

   // ************************************************************
   // infrared receive filter
   // ************************************************************
   reg  [7:0]  flt_cnt_ff;
   reg         flt_run_ff;
   reg         rxd_prev_ff;
   reg  [19:0] low_cnt_ff;
   wire        rx_fall;
   wire        rx_rise;
   wire [19:0] bit_len;

   assign rx_fall = rxd_prev_ff & ~rxd_pin;
   assign rx_rise = ~rxd_prev_ff & rxd_pin;
   assign bit_len = {brgr_ff[15:0], 4'h0};

   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         flt_cnt_ff  <= `ULM_RST_IF;
         flt_run_ff  <= 1'b0;
         rxd_prev_ff <= 1'b1;
         low_cnt_ff  <= 20'h00000;
      end else begin
         rxd_prev_ff <= rxd_pin;
         if (low_cnt_ff != 20'h00000)
            low_cnt_ff <= low_cnt_ff - 20'h00001;
         if (!is_irda || rx_rise) begin
            flt_run_ff <= 1'b0;
            flt_cnt_ff <= if_ff;
         end else if (flt_run_ff && flt_cnt_ff == 8'h00) begin
            flt_run_ff <= 1'b0;
            flt_cnt_ff <= if_ff;
            low_cnt_ff <= (bit_len == 20'h00000) ? 20'h00001 : bit_len;
         end else if (flt_run_ff) begin
            flt_cnt_ff <= flt_cnt_ff - 8'h01;
         end else begin
            // idle counter loaded, fall starts it
            flt_cnt_ff <= if_ff;
            flt_run_ff <= rx_fall;
         end
      end
   end

   // ************************************************************
   // channel routing
   // ************************************************************
   reg  txd_ff;
   reg  rx_in_ff;
   wire rx_src;

   assign rx_src = is_irda ? (low_cnt_ff == 20'h00000) : rxd_pin;

   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         txd_ff   <= 1'b1;
         rx_in_ff <= 1'b1;
      end else begin
         case (chm)
            `ULM_CHM_NORMAL: begin
               txd_ff   <= tx_bit;
               rx_in_ff <= rx_src;
            end
            `ULM_CHM_ECHO: begin
               txd_ff   <= rxd_pin;
               rx_in_ff <= rx_src;
            end
            `ULM_CHM_LOCAL: begin
               txd_ff   <= 1'b1;
               rx_in_ff <= tx_bit;
            end
            default: begin
               txd_ff   <= rxd_pin;
               rx_in_ff <= 1'b1;
            end
         endcase
      end
   end

   assign txd_pin  = txd_ff;
   assign rx_in    = rx_in_ff;
   assign txrx_off = (chm == `ULM_CHM_REMOTE);

   // ************************************************************
   // read multiplexer
   // ************************************************************
   always @* begin
      nxt_rdata = `ULM_RST_ZERO;
      if (avs_read && !ack_ff) begin
         case (avs_address)
            `ULM_OFS_MR:   nxt_rdata = mr_ff;
            `ULM_OFS_IMR:  nxt_rdata = {12'h000, imr_ff, 16'h0000};
            `ULM_OFS_CSR: begin
               nxt_rdata[`ULM_CSR_CHG_LO +: 4] = nxt_chg;
               nxt_rdata[`ULM_CSR_LVL_LO +: 4] = lvl_ff;
               nxt_rdata[`ULM_CSR_TX_IDLE]     = tx_empty;
            end
            `ULM_OFS_RHR:  nxt_rdata = {23'h000000, rx_hold_data};
            `ULM_OFS_BRGR: nxt_rdata = brgr_ff;
            `ULM_OFS_RTOR: nxt_rdata = rtor_ff;
            `ULM_OFS_TTGR: nxt_rdata = ttgr_ff;
            `ULM_OFS_FIDI: nxt_rdata = fidi_ff;
            `ULM_OFS_NER:  nxt_rdata = {24'h000000, err_count};
            `ULM_OFS_IF:   nxt_rdata = {24'h000000, if_ff};
            `ULM_OFS_MAN:  nxt_rdata = man_ff;
            default:       nxt_rdata = `ULM_RST_ZERO;
         endcase
      end else begin
         nxt_rdata = rdata_ff;
      end
   end

endmodule // ulm_line_modes

// File: rtl/ulm_defs.vh
// register offsets, field positions and reset values of the line-mode block
`ifndef ULM_DEFS_VH
`define ULM_DEFS_VH

`define ULM_OFS_CR      8'h00
`define ULM_OFS_MR      8'h04
`define ULM_OFS_IER     8'h08
`define ULM_OFS_IDR     8'h0C
`define ULM_OFS_IMR     8'h10
`define ULM_OFS_CSR     8'h14
`define ULM_OFS_RHR     8'h18
`define ULM_OFS_THR     8'h1C
`define ULM_OFS_BRGR    8'h20
`define ULM_OFS_RTOR    8'h24
`define ULM_OFS_TTGR    8'h28
`define ULM_OFS_FIDI    8'h40
`define ULM_OFS_NER     8'h44
`define ULM_OFS_IF      8'h4C
`define ULM_OFS_MAN     8'h50

`define ULM_CR_DTR_ON   16
`define ULM_CR_DTR_OFF  17
`define ULM_CR_RTS_ON   18
`define ULM_CR_RTS_OFF  19

`define ULM_MR_MODE_LO  0
`define ULM_MR_CHM_LO   14
`define ULM_MODE_RS485  4'h1
`define ULM_MODE_MODEM  4'h3
`define ULM_MODE_IRDA   4'h8
`define ULM_CHM_NORMAL  2'h0
`define ULM_CHM_ECHO    2'h1
`define ULM_CHM_LOCAL   2'h2
`define ULM_CHM_REMOTE  2'h3

`define ULM_CSR_TX_IDLE 9
`define ULM_CSR_CHG_LO  16
`define ULM_CSR_LVL_LO  20

`define ULM_RST_ZERO    32'h00000000
`define ULM_RST_FIDI    32'h00000174
`define ULM_RST_IF      8'h00
`define ULM_BIT_SHIFT   4

`endif

// File: bench/ulm_properties.sv
// port-level assertions for the serial line-mode block
`timescale 1ns/1ps
module ulm_properties (
   input wire        clk_sys,
   input wire        nrst,
   input wire [7:0]  avs_address,
   input wire        avs_write,
   input wire [31:0] avs_writedata,
   input wire        avs_waitrequest,
   input wire        rxd_pin,
   input wire        txd_pin,
   input wire        rts_pin,
   input wire        dtr_pin,
   input wire        cts_pin,
   input wire        tx_bit,
   input wire        tx_empty,
   input wire        tx_shifting,
   input wire        tg_active,
   input wire        rx_in,
   input wire        tx_allow,
   input wire        txrx_off,
   input wire [31:0] mode_cfg
);
   wire [3:0] md  = mode_cfg[3:0];
   wire [1:0] chm = mode_cfg[15:14];
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!nrst);
   sequence s_cr_cmd;
      avs_write && !avs_waitrequest && avs_address == 8'h00;
   endsequence
   a_rs485_rts_follow: assert property (
      $past(md) == 4'h1 && !$past(tg_active) |-> rts_pin == !$past(tx_empty))
      else $error("rts does not follow tx empty in rs485");
   a_rs485_guard_high: assert property (
      $past(md) == 4'h1 && $past(tg_active) |-> rts_pin)
      else $error("rts low during timeguard");
   a_rts_off_cmd: assert property (
      s_cr_cmd ##0 (avs_writedata[19] && md != 4'h1) |-> ##[1:2] rts_pin)
      else $error("rts not driven high by disable command");
   a_dtr_on_cmd: assert property (
      s_cr_cmd ##0 (avs_writedata[16] && !avs_writedata[17])
      |-> ##[1:2] !dtr_pin)
      else $error("dtr not driven low by enable command");
   a_cts_stops_tx: assert property (
      (md == 4'h3 && cts_pin && !tx_shifting) [*4] |-> !tx_allow)
      else $error("transmitter allowed while cts inactive");
   a_normal_route: assert property (
      $past(chm) == 2'h0 && $past(md) != 4'h8
      |-> rx_in == $past(rxd_pin) && txd_pin == $past(tx_bit))
      else $error("normal routing broken");
   a_echo_route: assert property (
      $past(chm) == 2'h1 |-> txd_pin == $past(rxd_pin))
      else $error("echo routing broken");
   a_local_loop: assert property (
      $past(chm) == 2'h2 |-> txd_pin && rx_in == $past(tx_bit))
      else $error("local loopback broken");
   a_remote_loop: assert property (
      chm == 2'h3 |-> txrx_off ##1 txd_pin == $past(rxd_pin))
      else $error("remote loopback broken");
endmodule // ulm_properties

bind ulm_line_modes ulm_properties u_props (
   .clk_sys, .nrst, .avs_address, .avs_write, .avs_writedata,
   .avs_waitrequest, .rxd_pin, .txd_pin, .rts_pin, .dtr_pin, .cts_pin,
   .tx_bit, .tx_empty, .tx_shifting, .tg_active, .rx_in, .tx_allow,
   .txrx_off, .mode_cfg
);

// File: bench/ulm_line_partner.sv
// modem and infrared transceiver model driving the line inputs
`timescale 1ns/1ps
module ulm_line_partner (
   input  wire clk_sys,
   output wire rxd_pin,
   output wire ri_pin,
   output wire dsr_pin,
   output wire dcd_pin,
   output wire cts_pin
);
   // lines idle high, order ri, dsr, dcd, cts
   reg       rxd_ff   = 1'h1;
   reg [3:0] lines_ff = 4'hF;
   assign rxd_pin = rxd_ff;
   assign {cts_pin, dcd_pin, dsr_pin, ri_pin} = lines_ff;
   task set_line(input integer k, input v);
      begin
         @(posedge clk_sys);
         lines_ff[k] <= v;
      end
   endtask
   task set_rxd(input v);
      begin
         @(posedge clk_sys);
         rxd_ff <= v;
      end
   endtask
   // light pulse: receive line low for len cycles
   task ir_pulse(input integer len);
      begin
         @(posedge clk_sys);
         rxd_ff <= 1'h0;
         repeat (len) @(posedge clk_sys);
         rxd_ff <= 1'h1;
      end
   endtask
endmodule // ulm_line_partner

// File: bench/testbench.sv
// self-checking bench for the serial line-mode block
`timescale 1ns/1ps
module testbench;
   reg         clk_sys       = 1'h0;
   reg         nrst          = 1'h0;
   reg  [7:0]  avs_address   = 8'h00;
   reg         avs_read      = 1'h0;
   reg         avs_write     = 1'h0;
   reg  [31:0] avs_writedata = 32'h0;
   reg         tx_bit        = 1'h1;
   reg         tx_empty      = 1'h1;
   reg         tx_shifting   = 1'h0;
   reg         tg_active     = 1'h0;
   wire [31:0] avs_readdata;
   wire        avs_waitrequest, rxd_pin, txd_pin, rts_pin, dtr_pin, irq;
   wire        cts_pin, dsr_pin, dcd_pin, ri_pin, rx_in, tx_allow, txrx_off;
   wire [31:0] baud_cfg, mode_cfg, rto_cfg, tg_cfg, fidi_cfg, man_cfg;
   wire [15:0] cmd_pulse;
   wire [8:0]  thr_data;
   wire        thr_wr;
   integer     pulse_n   = 0;
   reg  [15:0] cmd_seen  = 16'h0000;
   reg  [8:0]  thr_seen  = 9'h000;
   integer     bad_count = 0;
   integer     checks    = 0;
   integer     cyc       = 0;
   reg  [31:0] rd;
   localparam [55:0] ZOFS = 56'h10_20_24_28_4C_50_48;
   always #25 clk_sys = ~clk_sys;
   ulm_line_modes dut (
      .clk_sys, .nrst, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_readdata, .avs_waitrequest, .rxd_pin, .txd_pin, .rts_pin,
      .dtr_pin, .cts_pin, .dsr_pin, .dcd_pin, .ri_pin, .tx_bit, .tx_empty,
      .tx_shifting, .tg_active, .rx_hold_data(9'h0A5), .err_count(8'h3C),
      .rx_in, .tx_allow, .txrx_off, .cmd_pulse, .thr_wr, .thr_data,
      .mode_cfg, .baud_cfg, .rto_cfg, .tg_cfg, .fidi_cfg,
      .man_cfg, .irq
   );
   ulm_line_partner line (
      .clk_sys, .rxd_pin, .ri_pin, .dsr_pin, .dcd_pin, .cts_pin
   );
   task chk(input [31:0] seen, input [31:0] exp);
      begin
         checks = checks + 1;
         if (seen !== exp) begin
            bad_count = bad_count + 1;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   // one bus cycle, held until waitrequest is sampled low
   task bus(input wr, input [7:0] a, input [31:0] d);
      begin
         avs_address <= a;
         avs_writedata <= d;
         avs_write <= wr;
         avs_read <= !wr;
         @(posedge clk_sys);
         while (avs_waitrequest !== 1'h0)
            @(posedge clk_sys);
         rd = avs_readdata;
         avs_write <= 1'h0;
         avs_read <= 1'h0;
         @(posedge clk_sys);
      end
   endtask
   task count_low(input integer len, output integer n);
      begin
         n = 0;
         repeat (len) begin
            @(posedge clk_sys);
            if (rx_in === 1'h0) n = n + 1;
         end
      end
   endtask
   task t_regs;
      integer i;
      begin
         bus(0, 8'h40, 0);
         chk(rd, 32'h174);
         bus(1, 8'h48, 32'hFFFFFFFF);
         bus(1, 8'h10, 32'hFFFFFFFF);
         for (i = 0; i < 7; i = i + 1) begin
            bus(0, ZOFS[8*i +: 8], 0);
            chk(rd, 0);
         end
         bus(0, 8'h18, 0);
         chk(rd, 32'hA5);
         bus(0, 8'h44, 0);
         chk(rd, 32'h3C);
         bus(1, 8'h20, 32'h1);
         chk(baud_cfg, 32'h1);
      end
   endtask
   task t_out;
      begin
         bus(1, 8'h24, 32'h12);
         bus(1, 8'h28, 32'h34);
         bus(1, 8'h40, 32'h56);
         bus(1, 8'h50, 32'h78);
         bus(1, 8'h1C, 32'h1A5);
         bus(1, 8'h00, 32'hF0);
         @(posedge clk_sys);
         chk(rto_cfg, 32'h12);
         chk(tg_cfg, 32'h34);
         chk(fidi_cfg, 32'h56);
         chk(man_cfg, 32'h78);
         chk(pulse_n, 2);
         chk(thr_seen, 9'h1A5);
         chk(thr_data, 9'h1A5);
         chk(cmd_seen, 16'h00F0);
         bus(0, 8'h24, 0);
         chk(rd, 32'h12);
         bus(0, 8'h50, 0);
         chk(rd, 32'h78);
      end
   endtask
   task t_route;
      integer c, v;
      begin
         for (c = 0; c < 4; c = c + 1) begin
            bus(1, 8'h04, c << 14);
            for (v = 0; v < 2; v = v + 1) begin
               tx_bit <= v[0];
               line.set_rxd(!v[0]);
               repeat (3) @(posedge clk_sys);
               chk(txrx_off, c == 3);
               chk(txd_pin, c == 0 ? v : c == 2 ? 1 : !v);
               chk(rx_in, c == 2 ? v : c == 3 ? 1 : !v);
            end
         end
      end
   endtask
   task t_rs485;
      integer i;
      begin
         bus(1, 8'h04, 32'h1);
         bus(0, 8'h04, 0);
         chk(rd, 32'h1);
         chk(mode_cfg, 32'h1);
         for (i = 0; i < 4; i = i + 1) begin
            tx_empty <= i[0];
            tg_active <= i[1];
            repeat (3) @(posedge clk_sys);
            chk(rts_pin, !i[0] | i[1]);
         end
         tg_active <= 1'h0;
      end
   endtask
   task t_modem;
      integer k;
      begin
         bus(1, 8'h04, 32'h3);
         for (k = 0; k < 4; k = k + 1) begin
            bus(1, 8'h00, 32'h1 << (16 + k));
            repeat (2) @(posedge clk_sys);
            chk({rts_pin, dtr_pin}, {k != 2, k != 0});
         end
         bus(1, 8'h08, 32'h000F0000);
         bus(0, 8'h14, 0);
         for (k = 0; k < 4; k = k + 1) begin
            line.set_line(k, 1'h0);
            repeat (4) @(posedge clk_sys);
            chk(irq, 1);
            bus(0, 8'h14, 0);
            chk(rd[23:16], {4'hF << (k + 1), 4'h1 << k});
            chk(irq, 0);
         end
         bus(1, 8'h0C, 32'h00010000);
         bus(0, 8'h10, 0);
         chk(rd, 32'h000E0000);
         line.set_line(0, 1'h1);
         repeat (4) @(posedge clk_sys);
         chk(irq, 0);
         bus(0, 8'h14, 0);
         chk(rd[19:16], 4'h1);
         chk(rd[9], 1'h1);
         tx_shifting <= 1'h1;
         line.set_line(3, 1'h1);
         repeat (4) @(posedge clk_sys);
         chk(tx_allow, 1);
         tx_shifting <= 1'h0;
         repeat (4) @(posedge clk_sys);
         chk(tx_allow, 0);
      end
   endtask
   task t_irda;
      integer n;
      begin
         bus(1, 8'h40, 32'h174);
         bus(1, 8'h4C, 32'h4);
         bus(1, 8'h04, 32'h8);
         fork
            line.ir_pulse(2);
            count_low(40, n);
         join
         chk(n, 0);
         fork
            line.ir_pulse(12);
            count_low(40, n);
         join
         chk(n, 16);
         bus(1, 8'h4C, 32'hFF);
         fork
            line.ir_pulse(200);
            count_low(210, n);
         join
         chk(n, 0);
      end
   endtask
   task print_verdict;
      begin
         $display("checks %0d mismatches %0d", checks, bad_count);
         if (bad_count == 0 && checks > 0)
            $display("ALL TESTS PASSED");
         else
            $display("TESTS FAILED");
         $finish;
      end
   endtask
   // pulse outputs are caught on the edge that ends them
   always @(posedge clk_sys) begin
      if (nrst) begin
         if (thr_wr) thr_seen <= thr_data;
         if (cmd_pulse != 16'h0000) cmd_seen <= cmd_pulse;
         pulse_n <= pulse_n + thr_wr + (cmd_pulse != 16'h0000);
      end
   end
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         bad_count = bad_count + 1;
         print_verdict;
      end
   end
   initial begin
      repeat (6) @(posedge clk_sys);
      nrst <= 1'h1;
      @(posedge clk_sys);
      t_regs;
      t_out;
      t_route;
      t_rs485;
      t_modem;
      t_irda;
      print_verdict;
   end
endmodule // testbench
